//--- rtl/eoc_pkg.sv
`default_nettype none
package eoc_pkg;
   // special-function register holding the external oscillator controls
   localparam logic [7:0] EOC_CTRL_ADDR  = 8'hb5;
   localparam logic [7:0] EOC_CTRL_RESET = 8'h00;
   localparam int EOC_VALID_BIT  = 7;
   localparam int EOC_MODE_HI    = 6;
   localparam int EOC_MODE_LO    = 4;
   localparam int EOC_UNUSED_BIT = 3;
   localparam int EOC_FREQ_HI    = 2;
   localparam int EOC_FREQ_LO    = 0;
   localparam logic [2:0] EOC_FREQ_RESET = 3'h0;

   typedef enum logic [2:0] {
      EOC_MODE_OFF       = 3'b000,
      EOC_MODE_RSVD      = 3'b001,
      EOC_MODE_CMOS      = 3'b010,
      EOC_MODE_CMOS_DIV2 = 3'b011,
      EOC_MODE_RC        = 3'b100,
      EOC_MODE_CAP       = 3'b101,
      EOC_MODE_XTAL      = 3'b110,
      EOC_MODE_XTAL_DIV2 = 3'b111
   } eoc_mode_t;

   typedef struct packed {
      eoc_mode_t  mode;
      logic [2:0] freq;
   } eoc_ctrl_t;

   localparam eoc_ctrl_t EOC_CTRL_INIT = '{mode: EOC_MODE_OFF,
                                           freq: EOC_FREQ_RESET};

   // timing: clock period and how long the amplitude detector must hold
   localparam int EOC_CLK_PERIOD_NS = 10;
   localparam int EOC_STABLE_NS     = 10000;
   localparam int EOC_STABLE_CYCLES =
      (EOC_STABLE_NS + EOC_CLK_PERIOD_NS - 1) / EOC_CLK_PERIOD_NS;
   localparam int EOC_CNT_W = 13;

   // capacitor-mode K factor, scaled by one hundred
   localparam int EOC_KF_W = 18;
   function automatic logic [EOC_KF_W-1:0] eoc_kfactor(
      input logic [2:0] code);
      logic [EOC_KF_W-1:0] kf;
      kf = 18'h00000;
      case (code)
         3'h0:    kf = 18'h00057;
         3'h1:    kf = 18'h00104;
         3'h2:    kf = 18'h00302;
         3'h3:    kf = 18'h00898;
         3'h4:    kf = 18'h01964;
         3'h5:    kf = 18'h04650;
         3'h6:    kf = 18'h10360;
         default: kf = 18'h26d18;
      endcase
      return kf;
   endfunction
endpackage
`default_nettype wire

//--- rtl/eoc_ctrl.sv
// Operation
// - bit 7 is a read-only crystal-valid flag, meaningful in crystal modes.
// - flag reads 0 while oscillator unused or unsettled, 1 once stable.
// - mode field in bits 6:4 selects off, CMOS, RC, cap or crystal modes.
// - bit 3 reads as 0 and writes to it are ignored.
// - bits 2:0 pick the drive band in crystal and RC modes.
// - in capacitor mode bits 2:0 pick the K factor, 0.87 up to 1590.
`timescale 1ns/1ns
`default_nettype none
module eoc_ctrl #(
   parameter int STABLE_CYCLES = eoc_pkg::EOC_STABLE_CYCLES
) (
   input  wire logic                         clk_sys,
   input  wire logic                         nrst,
   input  wire logic [7:0]                   sfr_addr,
   input  wire logic                         sfr_wr,
   input  wire logic                         sfr_rd,
   input  wire logic [7:0]                   sfr_wdata,
   output var  logic [7:0]                   sfr_rdata,
   input  wire logic                         amp_detect,
   input  wire logic                         crystal_in_pin,
   output var  logic                         crystal_valid_flag,
   output var  logic [2:0]                   ext_osc_mode_select,
   output var  logic [2:0]                   ext_freq_control,
   output var  logic                         osc_enable,
   output var  logic                         xtal_pins_analog,
   output var  logic [2:0]                   xtal_band,
   output var  logic [2:0]                   rc_band,
   output var  logic [eoc_pkg::EOC_KF_W-1:0] cap_kfactor_x100,
   output var  logic                         osc_clk_out
);
   eoc_pkg::eoc_ctrl_t ctrl_reg;
   eoc_pkg::eoc_ctrl_t ctrl_next;
   logic [eoc_pkg::EOC_CNT_W-1:0] stable_cnt_reg;
   logic [eoc_pkg::EOC_CNT_W-1:0] stable_cnt_next;
   logic                          valid_reg;
   logic                          valid_next;
   logic [7:0]                    rdata_reg;
   logic [7:0]                    rdata_next;
   logic                          clk_in_d_reg;
   logic                          clk_out_reg;
   logic                          clk_out_next;
   logic                          enable_reg;
   logic                          analog_reg;
   logic [2:0]                    xband_reg;
   logic [2:0]                    rband_reg;
   logic [eoc_pkg::EOC_KF_W-1:0]  kf_reg;

   localparam logic [eoc_pkg::EOC_CNT_W-1:0] STABLE_LAST =
      eoc_pkg::EOC_CNT_W'(STABLE_CYCLES - 1);

   wire addr_hit  = (sfr_addr == eoc_pkg::EOC_CTRL_ADDR);
   wire wr_hit    = addr_hit & sfr_wr;
   wire rd_hit    = addr_hit & sfr_rd;

   // decode of the stored mode field
   wire mode_xtal = (ctrl_reg.mode == eoc_pkg::EOC_MODE_XTAL) |
                    (ctrl_reg.mode == eoc_pkg::EOC_MODE_XTAL_DIV2);
   wire mode_cmos = (ctrl_reg.mode == eoc_pkg::EOC_MODE_CMOS) |
                    (ctrl_reg.mode == eoc_pkg::EOC_MODE_CMOS_DIV2);
   wire mode_rc   = (ctrl_reg.mode == eoc_pkg::EOC_MODE_RC);
   wire mode_cap  = (ctrl_reg.mode == eoc_pkg::EOC_MODE_CAP);
   wire mode_half = (ctrl_reg.mode == eoc_pkg::EOC_MODE_CMOS_DIV2) |
                    (ctrl_reg.mode == eoc_pkg::EOC_MODE_XTAL_DIV2);
   // reserved code 001 drives nothing, same as off
   wire mode_on   = mode_xtal | mode_cmos | mode_rc | mode_cap;

   // bit 7 and bit 3 of a write are dropped
   assign ctrl_next = wr_hit ?
      eoc_pkg::eoc_ctrl_t'({sfr_wdata[eoc_pkg::EOC_MODE_HI:
                                      eoc_pkg::EOC_MODE_LO],
                            sfr_wdata[eoc_pkg::EOC_FREQ_HI:
                                      eoc_pkg::EOC_FREQ_LO]}) :
      ctrl_reg;

   // amplitude detector must hold for the whole window; any drop or a
   // mode change restarts it, so a glitchy start never reports valid
   wire mode_change  = wr_hit &
      (ctrl_next.mode != ctrl_reg.mode);
   wire count_run    = mode_xtal & amp_detect & ~mode_change;
   wire count_done   = (stable_cnt_reg == STABLE_LAST);
   assign stable_cnt_next = !count_run ? '0 :
      (count_done ? stable_cnt_reg :
       stable_cnt_reg + eoc_pkg::EOC_CNT_W'(1));
   assign valid_next = count_run & count_done;

   assign rdata_next = rd_hit ?
      {valid_reg, ctrl_reg.mode, 1'b0, ctrl_reg.freq} :
      8'h00;

   // halved modes toggle on each rising input edge; the divider trades
   // half the rate for a clean duty cycle
   wire in_rise = crystal_in_pin & ~clk_in_d_reg;
   assign clk_out_next = !mode_on ? 1'b0 :
      (mode_half ? (clk_out_reg ^ in_rise) : crystal_in_pin);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg       <= eoc_pkg::EOC_CTRL_INIT;
         stable_cnt_reg <= '0;
         valid_reg      <= 1'b0;
         rdata_reg      <= eoc_pkg::EOC_CTRL_RESET;
         clk_in_d_reg   <= 1'b0;
         clk_out_reg    <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         stable_cnt_reg <= stable_cnt_next;
         valid_reg      <= valid_next;
         rdata_reg      <= rdata_next;
         clk_in_d_reg   <= crystal_in_pin;
         clk_out_reg    <= clk_out_next;
      end
   end

   // analog-side controls follow the stored fields one cycle later
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         enable_reg <= 1'b0;
         analog_reg <= 1'b0;
         xband_reg  <= eoc_pkg::EOC_FREQ_RESET;
         rband_reg  <= eoc_pkg::EOC_FREQ_RESET;
         kf_reg     <= '0;
      end else begin
         enable_reg <= mode_on;
         analog_reg <= mode_xtal;
         xband_reg  <= mode_xtal ? ctrl_reg.freq : '0;
         rband_reg  <= mode_rc ? ctrl_reg.freq : '0;
         kf_reg     <= mode_cap ?
            eoc_pkg::eoc_kfactor(ctrl_reg.freq) : '0;
      end
   end

   assign sfr_rdata           = rdata_reg;
   assign crystal_valid_flag  = valid_reg;
   assign ext_osc_mode_select = ctrl_reg.mode;
   assign ext_freq_control    = ctrl_reg.freq;
   assign osc_enable          = enable_reg;
   assign xtal_pins_analog    = analog_reg;
   assign xtal_band           = xband_reg;
   assign rc_band             = rband_reg;
   assign cap_kfactor_x100    = kf_reg;
   assign osc_clk_out         = clk_out_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // of the writes, only a real mode change restarts the window; a same-mode rewrite keeps it
   sequence s_write_xtal;
      mode_change && sfr_wdata[eoc_pkg::EOC_MODE_HI:eoc_pkg::EOC_MODE_HI-1]
         == 2'b11;
   endsequence
   sequence s_amp_hold;
      mode_xtal && amp_detect && !wr_hit;
   endsequence

   valid_needs_xtal_a: assert property (
      crystal_valid_flag |-> mode_xtal)
      else $error("valid flag set outside crystal mode");
   valid_late_a: assert property (
      !mode_xtal |=> !crystal_valid_flag)
      else $error("valid flag not cleared when crystal unused");
   valid_drop_a: assert property (
      (mode_xtal && !amp_detect) |=> !crystal_valid_flag)
      else $error("valid flag held without amplitude");
   valid_settle_a: assert property (
      (s_write_xtal ##1 s_amp_hold [*8]) |-> !crystal_valid_flag)
      else $error("valid flag set before settling window");
   mode_store_a: assert property (
      wr_hit |=> ext_osc_mode_select ==
         $past(sfr_wdata[eoc_pkg::EOC_MODE_HI:eoc_pkg::EOC_MODE_LO]))
      else $error("mode field not stored from write");
   rsvd_off_a: assert property (
      (ext_osc_mode_select == eoc_pkg::EOC_MODE_RSVD) ##1
      (ext_osc_mode_select == eoc_pkg::EOC_MODE_RSVD) |->
      !osc_enable && !osc_clk_out)
      else $error("reserved mode enabled the oscillator");
   unused_zero_a: assert property (
      rd_hit |=> sfr_rdata[eoc_pkg::EOC_UNUSED_BIT] == 1'b0 &&
         sfr_rdata[eoc_pkg::EOC_VALID_BIT] == $past(valid_reg))
      else $error("read of bit 3 or bit 7 wrong");
   band_route_a: assert property (
      mode_rc |=> rc_band == $past(ctrl_reg.freq) && xtal_band == 3'h0)
      else $error("rc band not routed");
   kfactor_a: assert property (
      (mode_cap && ctrl_reg.freq == 3'h3) |=> cap_kfactor_x100 == 18'h00898)
      else $error("k factor wrong for code 011");

   // flag may only rise with amplitude seen both one cycle and eight cycles earlier
   valid_window_a: assert property (
      $rose(crystal_valid_flag) |->
         $past(amp_detect) && $past(amp_detect, 8))
      else $error("valid flag rose without a full window");
   freq_store_a: assert property (
      wr_hit |=> ext_freq_control ==
         $past(sfr_wdata[eoc_pkg::EOC_FREQ_HI:eoc_pkg::EOC_FREQ_LO]))
      else $error("band field not stored from write");
   xband_route_a: assert property (
      mode_xtal |=> xtal_band == $past(ctrl_reg.freq) &&
         rc_band == 3'h0 && xtal_pins_analog)
      else $error("crystal band not routed");
   kfactor_low_a: assert property (
      (mode_cap && ctrl_reg.freq == 3'h0) |=> cap_kfactor_x100 == 18'h00057)
      else $error("k factor wrong for code 000");
   kfactor_top_a: assert property (
      (mode_cap && ctrl_reg.freq == 3'h7) |=> cap_kfactor_x100 == 18'h26d18)
      else $error("k factor wrong for code 111");
   off_idle_a: assert property (
      (ext_osc_mode_select == eoc_pkg::EOC_MODE_OFF) ##1
      (ext_osc_mode_select == eoc_pkg::EOC_MODE_OFF) |->
      !osc_enable && !xtal_pins_analog && cap_kfactor_x100 == '0)
      else $error("off mode still drives the oscillator");
   rdata_idle_a: assert property (
      !rd_hit |=> sfr_rdata == 8'h00)
      else $error("read data did not return to zero");
endmodule
`default_nettype wire

//--- rtl/eoc_ctrl_note.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- testbench/eoc_xtal_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: crystal network and amplitude detector
module eoc_xtal_model #(
   parameter int SETTLE = 20
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic osc_enable,
   input  wire logic xtal_pins_analog,
   input  wire logic fail,
   output var  logic amp_detect,
   output var  logic crystal_in_pin
);
   int cnt;
   // detector needs bias time before it reports good amplitude
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         amp_detect <= 1'b0;
         crystal_in_pin <= 1'b0;
      end else begin
         cnt <= (xtal_pins_analog && !fail) ? cnt + 1 : 0;
         amp_detect <= xtal_pins_analog && !fail && (cnt >= SETTLE);
         // pin grounded by firmware while the circuit is off
         crystal_in_pin <= osc_enable ? !crystal_in_pin : 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- testbench/external_oscillator_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module external_oscillator_control_tb_top;
   localparam int STABLE = 12;
   logic clk_sys, nrst, sfr_wr, sfr_rd, amp_detect, crystal_in_pin, fail;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
   logic       valid, osc_en, analog, osc_clk;
   logic [2:0] mode_q, freq_q, xband, rband;
   logic [17:0] kf;
   logic [17:0] kf_tab [8] = '{18'h00057, 18'h00104, 18'h00302, 18'h00898,
                               18'h01964, 18'h04650, 18'h10360, 18'h26d18};
   int mismatches = 0;
   int cmp_count = 0;
   eoc_ctrl #(.STABLE_CYCLES(STABLE)) dut (.clk_sys(clk_sys), .nrst(nrst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .amp_detect(amp_detect),
      .crystal_in_pin(crystal_in_pin), .crystal_valid_flag(valid),
      .ext_osc_mode_select(mode_q), .ext_freq_control(freq_q),
      .osc_enable(osc_en), .xtal_pins_analog(analog), .xtal_band(xband),
      .rc_band(rband), .cap_kfactor_x100(kf), .osc_clk_out(osc_clk));
   eoc_xtal_model #(.SETTLE(20)) xtal (.clk_sys(clk_sys), .nrst(nrst),
      .osc_enable(osc_en), .xtal_pins_analog(analog), .fail(fail),
      .amp_detect(amp_detect), .crystal_in_pin(crystal_in_pin));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
   endtask
   task automatic sfr_read(input logic [7:0] a);
      @(posedge clk_sys);
      sfr_addr <= a; sfr_rd <= 1'b1;
      @(posedge clk_sys);
      sfr_rd <= 1'b0;
      #1 rd = sfr_rdata;
   endtask
   // every mode against every band code, derived outputs and read-back
   task automatic mode_table();
      for (int m = 0; m < 8; m++) begin
         for (int f = 0; f < 8; f++) begin
            sfr_write(8'hb5, {1'b1, m[2:0], 1'b1, f[2:0]});
            #1 check(18'(mode_q), 18'(m[2:0]));
            check(18'(freq_q), 18'(f[2:0]));
            @(posedge clk_sys);
            #1 check(18'(osc_en), 18'(m > 1));
            check(18'(analog), 18'(m >= 6));
            check(18'(xband), (m >= 6) ? 18'(f[2:0]) : 18'h0);
            check(18'(rband), (m == 4) ? 18'(f[2:0]) : 18'h0);
            check(kf, (m == 5) ? kf_tab[f] : 18'h0);
            sfr_read(8'hb5);
            check(18'(rd & 8'h7f), 18'({m[2:0], 1'b0, f[2:0]}));
         end
      end
   endtask
   // clock path: follows the pin, halves it, or stands still when off
   task automatic clk_path();
      int pin_rises;
      int out_rises;
      logic pin_q;
      logic out_q;
      for (int k = 0; k < 3; k++) begin
         sfr_write(8'hb5, (k == 0) ? 8'h20 : (k == 1) ? 8'h30 : 8'h00);
         repeat (4) @(posedge clk_sys);
         #1 pin_q = crystal_in_pin;
         out_q = osc_clk;
         pin_rises = 0;
         out_rises = 0;
         repeat (16) begin
            @(posedge clk_sys);
            #1 pin_rises += int'(crystal_in_pin & ~pin_q);
            out_rises += int'(osc_clk & ~out_q);
            pin_q = crystal_in_pin;
            out_q = osc_clk;
         end
         // far side toggles each cycle: 8 rises in 16, halved gives 4
         check(18'(out_rises), 18'((k == 0) ? 8 : (k == 1) ? 4 : 0));
         check(18'(pin_rises), 18'((k == 2) ? 0 : 8));
      end
   endtask
   // start-up as firmware does it, then loss of amplitude
   task automatic crystal_start();
      int n;
      sfr_write(8'hb5, 8'h00);
      sfr_write(8'hb5, 8'h61); // pins already grounded; crystal mode makes them analog
      repeat (8) @(posedge clk_sys); // scaled settling wait
      sfr_read(8'hb5);
      check(18'(rd[7]), 18'h0);
      n = 0;
      do begin
         sfr_read(8'hb5); // poll before any clock switch
         n++;
      end while (rd[7] !== 1'b1 && n < 60);
      if (rd[7] !== 1'b1) begin
         mismatches++;
         finish_test();
      end
      // missing-clock detector is taken as enabled off-block here
      check(18'(rd), 18'he1);
      sfr_write(8'hb5, 8'h60); // band down after settling
      sfr_read(8'hb5);
      check(18'(rd), 18'he0);
      // 110 to 111 restarts the window although amplitude stays good
      sfr_write(8'hb5, 8'h70);
      for (int k = 0; k < STABLE; k++) begin
         #1 check(18'(valid), 18'h0);
         @(posedge clk_sys);
      end
      #1 check(18'(valid), 18'h1);
      sfr_read(8'hb5);
      check(18'(rd), 18'hf0);
      fail <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check(18'(valid), 18'h0);
      fail <= 1'b0;
      sfr_write(8'hb5, 8'h43); // rc mode, flag not meaningful
      sfr_read(8'hb5);
      check(18'(rd), 18'h43);
   endtask
   task automatic unmapped();
      sfr_write(8'hb4, 8'h7f);
      sfr_read(8'hb5);
      check(18'(rd), 18'h43);
      // read data stands one cycle only
      @(posedge clk_sys);
      #1 check(18'(sfr_rdata), 18'h0);
      sfr_read(8'hb4);
      check(18'(rd), 18'h0);
   endtask
   // reset in mid-run clears the register and every derived output
   task automatic reset_midrun();
      sfr_write(8'hb5, 8'h65);
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      #1 check(18'({valid, mode_q, freq_q, osc_en, analog}), 18'h0);
      check(18'({xband, rband, osc_clk}), 18'h0);
      check(kf, 18'h0);
      repeat (11) @(posedge clk_sys);
      nrst <= 1'b1;
      sfr_read(8'hb5);
      check(18'(rd), 18'h00);
   endtask
   initial begin
      nrst = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      fail = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      sfr_read(8'hb5);
      check(18'(rd), 18'h00);
      mode_table();
      clk_path();
      crystal_start();
      unmapped();
      reset_midrun();
      finish_test();
   end
endmodule
`default_nettype wire
